// ### hdl/qeb_fifo.sv
// Purpose: Word FIFO with registered read data, valid and ready on both sides.
// Assumes: DEPTH is a power of two; clr empties it in one cycle.
// Notes: The head word sits in an output register, so it is read with no delay.
`timescale 1ns/1ps
module qeb_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 16
) (
    input wire logic clk_i, // System clock.
    input wire logic nrst_i, // Asynchronous reset, low.
    input wire logic clr_i, // Synchronous flush.
    input wire logic [WIDTH-1:0] in_data_i, // Word to store.
    input wire logic in_valid_i, // Word offered.
    output logic in_ready_o, // Room for a word.
    output logic [WIDTH-1:0] out_data_o, // Head word.
    output logic out_valid_o, // Head word present.
    input wire logic out_ready_i // Head word taken.
);
    localparam int unsigned AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("DEPTH must be a power of two");
    end
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic [WIDTH-1:0] dout;
        logic ov;
    } qeb_fifo_state_type;
    qeb_fifo_state_type s_q, s_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, load;

    assign in_ready_o = (s_q.cnt != (AW+1)'(DEPTH));
    assign push = in_valid_i && in_ready_o && !clr_i;
    assign load = (!s_q.ov || out_ready_i) && (s_q.cnt != '0) && !clr_i;
    assign out_data_o = s_q.dout;
    assign out_valid_o = s_q.ov;

    always_comb begin
        s_d = s_q;
        if (push) s_d.wp = s_q.wp + 1'b1;
        if (load) begin
            s_d.rp = s_q.rp + 1'b1;
            s_d.dout = mem[s_q.rp];
            s_d.ov = 1'b1;
        end else if (out_ready_i) begin
            s_d.ov = 1'b0;
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(load);
        if (clr_i) s_d = '0;
    end

    always_ff @(posedge clk_i) begin
        if (push) mem[s_q.wp] <= in_data_i;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) s_q <= '0;
        else s_q <= s_d;
    end
endmodule

// ### hdl/qeb_formatter.sv
// Purpose: Build event records from converter results and serve them on the bus.
// Assumes: One gate result at a time; threshold compare happens upstream.
// Notes: Gates arriving while an event is still being built are dropped (busy).
`timescale 1ns/1ps
// Summary of operation
// RULE_01: Event words read from read-only window.
// RULE_02: Event is header, data words, end word.
// RULE_03: Header holds slot, 010, chassis, count.
// RULE_04: Data word type 000 and channel number.
// RULE_05: Bit 13 marks value below threshold.
// RULE_06: Below-threshold kept only when bits 3,4 set.
// RULE_07: Bit 12 marks converter overflow.
// RULE_08: Bits 11..0 hold converted value.
// RULE_09: End word holds slot, 100, event counter.
// RULE_10: Only codes 010,000,100,110 are emitted.
// RULE_11: Empty read returns not-valid word 110.
// RULE_12: Slot identifier in bits 31..27.
// RULE_13: Channels stored in interleaved order.
// RULE_14: Suppressed or killed channels are omitted.
// RULE_15: Gate with no stored channel stores nothing.
// RULE_16: Each stored event advances the slot pointer.
// RULE_17: Count-all mode counts empty gates too.
// RULE_18: Broadcast writes accepted, write-only.
// RULE_19: Master writes slot id without backplane connector.
// RULE_20: Ready flag while a complete event stored.
// RULE_21: Slot id defaults ones, applies after reset.
// RULE_22: Not-valid word otherwise all zeros.
module qeb_formatter #(
    parameter int unsigned NCH = 32,
    parameter int unsigned DEPTH = 16
) (
    input wire logic SYS_CLK_I, // 10 MHz system clock.
    input wire logic NRST_I, // Asynchronous reset, low.
    input wire qeb_pkg::qeb_busreq_type BUS_REQ_I, // Register bus request.
    output logic [31:0] BUS_RDATA_O, // Read data.
    output logic BUS_ACK_O, // Cycle answered.
    input wire logic CONV_GATE_I, // Results below are valid.
    input wire logic [NCH*qeb_pkg::VAL_W-1:0] CONV_VALUE_I, // Values.
    input wire logic [NCH-1:0] CONV_OVF_I, // Overflow per channel.
    input wire logic [NCH-1:0] CONV_UNDER_I, // Below threshold.
    input wire logic AUX_PRESENT_I, // Slot connector fitted.
    input wire logic [4:0] GEO_SLOT_I, // Slot from backplane.
    output logic EVENT_AVAILABLE_O, // Complete event stored.
    output logic BUSY_O // Gate would be dropped.
);
    localparam int unsigned CW = $clog2(NCH);
    localparam int unsigned VW = qeb_pkg::VAL_W;
    if (NCH != 16 && NCH != 32) begin : g_bad_nch
        $error("NCH must be 16 or 32");
    end
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_HEAD = 4'h2,
        ST_DATA = 4'h4,
        ST_TAIL = 4'h8
    } qeb_st_type;
    typedef struct packed {
        qeb_st_type st;
        logic [CW-1:0] k;
        logic [NCH-1:0] qual;
        logic [NCH-1:0] ovf;
        logic [NCH-1:0] under;
        logic [NCH-1:0][VW-1:0] vals;
        logic [5:0] ncnt;
        logic [qeb_pkg::EVC_W-1:0] evsnap;
        logic [qeb_pkg::EVC_W-1:0] evcnt;
        logic [7:0] events;
        logic [7:0] slot;
        logic [4:0] geo;
        logic [4:0] geo_pend;
        logic init;
        logic [7:0] crate;
        logic [15:0] bs2;
        logic [NCH-1:0] kill;
        logic [31:0] rdata;
        logic ack;
        logic busy;
        logic event_available_flag;
        logic clr;
    } qeb_state_type;
    qeb_state_type s_q, s_d;
    logic [CW-1:0] ch;
    logic [31:0] word;
    logic push_v, push_rdy, pop_rdy, out_v, win_rd, eoe_push, eoe_pop;
    logic [31:0] out_w;
    logic [NCH-1:0] qmask;
    logic [5:0] qcnt;
    logic [15:0] a;
    logic wr, rd;
    qeb_pkg::qeb_header_type hw;
    qeb_pkg::qeb_data_type dw;
    qeb_pkg::qeb_eoe_type ew;

    assign a = BUS_REQ_I.addr;
    assign wr = BUS_REQ_I.wr;
    assign rd = BUS_REQ_I.rd && !BUS_REQ_I.broadcast_write; // see RULE_18
    assign ch = {s_q.k[0], s_q.k[CW-1:1]}; // see RULE_13
    assign win_rd = rd && (a <= qeb_pkg::WIN_LAST); // see RULE_01
    assign pop_rdy = win_rd && out_v;

    // ****************************************
    // Channel qualification
    // ****************************************
    always_comb begin
        qmask = ~s_q.kill; // see RULE_14
        qcnt = '0;
        for (int i = 0; i < NCH; i++) begin
            if (CONV_OVF_I[i] && !s_q.bs2[qeb_pkg::BS2_OVF_KEEP]) qmask[i] = 1'b0;
            if (CONV_UNDER_I[i] && !(s_q.bs2[qeb_pkg::BS2_OVF_KEEP]
                    && s_q.bs2[qeb_pkg::BS2_UNDER_KEEP])) qmask[i] = 1'b0; // see RULE_06
            qcnt = qcnt + 6'(qmask[i]);
        end
    end

    // ****************************************
    // Word assembly
    // ****************************************
    always_comb begin
        hw = '0;
        hw.geo = s_q.geo; // see RULE_12
        hw.wtype = qeb_pkg::TYPE_HEAD; // see RULE_03
        hw.crate = s_q.crate;
        hw.stored_channel_count = s_q.ncnt;
        dw = '0;
        dw.geo = s_q.geo;
        dw.wtype = qeb_pkg::TYPE_DATA; // see RULE_04
        dw.chan = (NCH == 32) ? 5'(ch) : 5'({ch, 1'b0});
        dw.below_threshold_flag = s_q.under[ch]; // see RULE_05
        dw.conversion_overflow_flag = s_q.ovf[ch]; // see RULE_07
        dw.value = s_q.vals[ch]; // see RULE_08
        ew.geo = s_q.geo;
        ew.wtype = qeb_pkg::TYPE_EOE; // see RULE_09
        ew.evcnt = s_q.evsnap;
        push_v = 1'b0;
        word = hw;
        case (s_q.st) // see RULE_10
            ST_HEAD: push_v = 1'b1;
            ST_DATA: begin
                push_v = s_q.qual[ch];
                word = dw;
            end
            ST_TAIL: begin
                push_v = 1'b1;
                word = ew;
            end
            default: push_v = 1'b0;
        endcase
    end

    assign eoe_push = push_v && push_rdy && (s_q.st == ST_TAIL);
    assign eoe_pop = pop_rdy && (out_w[26:24] == qeb_pkg::TYPE_EOE);

    qeb_fifo #(
        .WIDTH(32),
        .DEPTH(DEPTH)
    ) u_store (
        .clk_i(SYS_CLK_I),
        .nrst_i(NRST_I),
        .clr_i(s_q.clr),
        .in_data_i(word),
        .in_valid_i(push_v),
        .in_ready_o(push_rdy),
        .out_data_o(out_w),
        .out_valid_o(out_v),
        .out_ready_i(pop_rdy)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.rdata = '0;
        s_d.clr = 1'b0;
        if (!s_q.init) begin
            s_d.init = 1'b1;
            s_d.geo = AUX_PRESENT_I ? GEO_SLOT_I : s_q.geo_pend; // see RULE_21
        end
        case (s_q.st)
            ST_IDLE: begin
                if (CONV_GATE_I) begin
                    s_d.qual = qmask;
                    s_d.ovf = CONV_OVF_I;
                    s_d.under = CONV_UNDER_I;
                    s_d.vals = CONV_VALUE_I;
                    s_d.ncnt = qcnt;
                    s_d.evsnap = s_q.evcnt;
                    s_d.k = '0;
                    if (qcnt != '0 || s_q.bs2[qeb_pkg::BS2_COUNT_ALL]) begin
                        s_d.evcnt = s_q.evcnt + 1'b1; // see RULE_17
                    end
                    if (qcnt != '0) s_d.st = ST_HEAD; // see RULE_15
                end
            end
            ST_HEAD: if (push_rdy) s_d.st = ST_DATA; // see RULE_02
            ST_DATA: begin
                if (!push_v || push_rdy) begin
                    s_d.k = s_q.k + 1'b1;
                    if (s_q.k == CW'(NCH-1)) s_d.st = ST_TAIL;
                end
            end
            ST_TAIL: begin
                if (push_rdy) begin
                    s_d.st = ST_IDLE;
                    s_d.slot = s_q.slot + 1'b1; // see RULE_16
                end
            end
            default: s_d.st = ST_IDLE;
        endcase
        s_d.events = s_q.events + 8'(eoe_push) - 8'(eoe_pop);
        // Register reads; the window pops one word per read.
        if (rd) begin
            s_d.ack = 1'b1;
            if (win_rd) s_d.rdata = out_v ? out_w : qeb_pkg::NVD_WORD; // see RULE_11, RULE_22
            else if (a == qeb_pkg::GEO_OFS) s_d.rdata = 32'(s_q.geo);
            else if (a == qeb_pkg::STAT1_OFS) begin
                s_d.rdata[qeb_pkg::ST1_READY_BIT] = s_q.event_available_flag;
                s_d.rdata[qeb_pkg::ST1_BUSY_BIT] = s_q.busy;
                s_d.rdata[qeb_pkg::ST1_AMNESIA_BIT] = !AUX_PRESENT_I;
            end
            else if (a == qeb_pkg::EVL_OFS) s_d.rdata = 32'(s_q.evcnt[15:0]);
            else if (a == qeb_pkg::EVH_OFS) s_d.rdata = 32'(s_q.evcnt[23:16]);
            else if (a == qeb_pkg::BS2_OFS) s_d.rdata = 32'(s_q.bs2);
            else if (a == qeb_pkg::CRATE_OFS) s_d.rdata = 32'(s_q.crate);
        end
        // Writes, direct or broadcast, land in the same registers.
        if (wr) begin
            s_d.ack = 1'b1; // see RULE_18
            if (a == qeb_pkg::GEO_OFS) begin
                // A fitted connector owns the slot id, so the cycle times out.
                s_d.ack = !AUX_PRESENT_I;
                if (!AUX_PRESENT_I) s_d.geo_pend = BUS_REQ_I.wdata[4:0]; // see RULE_19
            end
            else if (a == qeb_pkg::BS2_OFS) s_d.bs2 = s_q.bs2 | BUS_REQ_I.wdata;
            else if (a == qeb_pkg::BC2_OFS) s_d.bs2 = s_q.bs2 & ~BUS_REQ_I.wdata;
            else if (a == qeb_pkg::CRATE_OFS) s_d.crate = BUS_REQ_I.wdata[7:0];
            else if (a == qeb_pkg::EVRST_OFS) s_d.evcnt = '0;
            else if (a >= qeb_pkg::THR_FIRST && a <= qeb_pkg::THR_LAST) begin
                if ((a - qeb_pkg::THR_FIRST) < 16'(2 * NCH)) begin
                    s_d.kill[CW'((a - qeb_pkg::THR_FIRST) >> 1)] =
                        BUS_REQ_I.wdata[qeb_pkg::THR_KILL_BIT];
                end
            end
            else if (a == qeb_pkg::SSRST_OFS) begin
                // Single shot reset: flush the store and reload the slot id.
                s_d.clr = 1'b1;
                s_d.st = ST_IDLE;
                s_d.events = '0;
                s_d.evcnt = '0;
                s_d.slot = '0;
                s_d.init = 1'b0; // see RULE_21
            end
        end
        s_d.event_available_flag = (s_d.events != '0); // see RULE_20
        s_d.busy = (s_d.st != ST_IDLE);
    end

    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.geo <= qeb_pkg::GEO_RST;
            s_q.geo_pend <= qeb_pkg::GEO_RST;
            s_q.crate <= qeb_pkg::CRATE_RST;
            s_q.bs2 <= qeb_pkg::BS2_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign BUS_RDATA_O = s_q.rdata;
    assign BUS_ACK_O = s_q.ack;
    assign EVENT_AVAILABLE_O = s_q.event_available_flag;
    assign BUSY_O = s_q.busy;

    // ****************************************
    // Checks
    // ****************************************
    logic [5:0] dcount_q;
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) dcount_q <= '0;
        else if (s_q.st == ST_HEAD) dcount_q <= '0;
        else if (push_v && push_rdy && s_q.st == ST_DATA) dcount_q <= dcount_q + 1'b1;
    end

    property p_empty_read;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        win_rd && !out_v |=> BUS_ACK_O && BUS_RDATA_O == 32'h0600_0000;
    endproperty
    a_empty_read: assert property (p_empty_read) else $error("bad not-valid word"); // see RULE_11
    property p_slot_field;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        push_v |-> word[31:27] == s_q.geo && word[26:24] != 3'h6;
    endproperty
    a_slot_field: assert property (p_slot_field) else $error("bad slot field"); // see RULE_12
    property p_header;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        s_q.st == ST_HEAD |-> word[26:24] == 3'h2 && word[15:14] == 2'h0
            && word[23:16] == s_q.crate && word[13:8] == $countones(s_q.qual);
    endproperty
    a_header: assert property (p_header) else $error("bad header word"); // see RULE_03
    property p_count_match;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        s_q.st == ST_TAIL |-> dcount_q == s_q.ncnt && word[26:24] == 3'h4;
    endproperty
    a_count_match: assert property (p_count_match) else $error("data count mismatch"); // see RULE_02
    property p_data_fields;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        s_q.st == ST_DATA && push_v |-> word[26:24] == 3'h0
            && word[13] == s_q.under[ch] && word[12] == s_q.ovf[ch] && s_q.qual[ch];
    endproperty
    a_data_fields: assert property (p_data_fields) else $error("bad data word"); // see RULE_05
    property p_empty_gate;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        s_q.st == ST_IDLE && CONV_GATE_I && qcnt == 6'h0 && !wr |=> s_q.st == ST_IDLE
            && s_q.evcnt == $past(s_q.evcnt) + 24'(s_q.bs2[qeb_pkg::BS2_COUNT_ALL]);
    endproperty
    a_empty_gate: assert property (p_empty_gate) else $error("empty gate mishandled"); // see RULE_17
    property p_ready_flag;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        eoe_push && !eoe_pop && !wr |=> EVENT_AVAILABLE_O ##0 s_q.slot == $past(s_q.slot) + 8'h1;
    endproperty
    a_ready_flag: assert property (p_ready_flag) else $error("ready flag missing"); // see RULE_20
    property p_geo_hold;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        s_q.init && wr && a == qeb_pkg::GEO_OFS |=> s_q.geo == $past(s_q.geo);
    endproperty
    a_geo_hold: assert property (p_geo_hold) else $error("slot id changed early"); // see RULE_21
    property p_bcast_read;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        BUS_REQ_I.rd && BUS_REQ_I.broadcast_write && !wr |=> !BUS_ACK_O;
    endproperty
    a_bcast_read: assert property (p_bcast_read) else $error("broadcast read answered"); // see RULE_18
    // A reserved code in the store would make a reader lose track of event borders.
    property p_word_type;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        push_v |-> word[26:24] == 3'h2 || word[26:24] == 3'h0 || word[26:24] == 3'h4;
    endproperty
    a_word_type: assert property (p_word_type) else $error("reserved word type"); // see RULE_10
endmodule

// ### hdl/qeb_pkg.sv
// Purpose: Shared constants, word layouts and bus carrier of the event formatter.
// Assumes: Register offsets are byte offsets from the module base address.
// Notes: Every offset, reset value and field position used by the design is here.
package qeb_pkg;
    localparam int unsigned VAL_W = 12;
    localparam int unsigned EVC_W = 24;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [15:0] WIN_LAST = 16'h07fc;
    localparam logic [15:0] GEO_OFS = 16'h1002;
    localparam logic [15:0] STAT1_OFS = 16'h100e;
    localparam logic [15:0] SSRST_OFS = 16'h1016;
    localparam logic [15:0] EVL_OFS = 16'h1024;
    localparam logic [15:0] EVH_OFS = 16'h1026;
    localparam logic [15:0] BS2_OFS = 16'h1032;
    localparam logic [15:0] BC2_OFS = 16'h1034;
    localparam logic [15:0] CRATE_OFS = 16'h103c;
    localparam logic [15:0] EVRST_OFS = 16'h1040;
    localparam logic [15:0] THR_FIRST = 16'h1080;
    localparam logic [15:0] THR_LAST = 16'h10bf;
    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int unsigned BS2_OVF_KEEP = 3;
    localparam int unsigned BS2_UNDER_KEEP = 4;
    localparam int unsigned BS2_COUNT_ALL = 14;
    localparam int unsigned THR_KILL_BIT = 8;
    localparam int unsigned ST1_READY_BIT = 0;
    localparam int unsigned ST1_BUSY_BIT = 2;
    localparam int unsigned ST1_AMNESIA_BIT = 4;
    localparam logic [4:0] GEO_RST = 5'h1f;
    localparam logic [7:0] CRATE_RST = 8'h00;
    localparam logic [15:0] BS2_RST = 16'h0000;
    // ****************************************
    // Word type codes
    // ****************************************
    localparam logic [2:0] TYPE_HEAD = 3'h2;
    localparam logic [2:0] TYPE_DATA = 3'h0;
    localparam logic [2:0] TYPE_EOE = 3'h4;
    localparam logic [2:0] TYPE_NVD = 3'h6;
    localparam logic [31:0] NVD_WORD = 32'h0600_0000;

    typedef struct packed {
        logic [4:0] geo;
        logic [2:0] wtype;
        logic [7:0] crate;
        logic [1:0] zero;
        logic [5:0] stored_channel_count;
        logic [7:0] rsv;
    } qeb_header_type;

    typedef struct packed {
        logic [4:0] geo;
        logic [2:0] wtype;
        logic [2:0] rsv;
        logic [4:0] chan;
        logic [1:0] zero;
        logic below_threshold_flag;
        logic conversion_overflow_flag;
        logic [VAL_W-1:0] value;
    } qeb_data_type;

    typedef struct packed {
        logic [4:0] geo;
        logic [2:0] wtype;
        logic [EVC_W-1:0] evcnt;
    } qeb_eoe_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic broadcast_write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } qeb_busreq_type;
endpackage

// ### tb/qeb_bus_master.sv
// Purpose: Behavioural register-bus master that issues one queued cycle per clock.
// Assumes: Requests change at the falling edge and last exactly one cycle.
// Notes: Idle queue entries give the spacing between cycles.
`timescale 1ns/1ps
module qeb_bus_master (
    input wire logic clk_i, // System clock.
    output qeb_pkg::qeb_busreq_type req_o // Request to the formatter.
);
    qeb_pkg::qeb_busreq_type q[$];

    initial begin
        req_o = '0;
        forever begin
            @(negedge clk_i);
            if (q.size() > 0) begin
                req_o = q.pop_front();
            end else begin
                // Stale address and data are inverted so an idle bus never looks held.
                req_o = {3'h0, ~req_o.addr, ~req_o.wdata};
            end
        end
    end
endmodule

// ### tb/test_qdc_event_buffer_formatter.sv
// Purpose: Self-checking bench for the event formatter.
// Assumes: Slot connector fitted until the last scenario, which writes the slot id instead.
// Notes: Reads are spaced so a stalled builder refills the store between them.
`timescale 1ns/1ps
module test_qdc_event_buffer_formatter;
    localparam int NCH = 32;
    localparam logic [4:0] SLOT = 5'h0b;
    typedef struct packed {
        logic chk;
        logic [31:0] val;
    } qeb_note_type;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic aux = 1'b1;
    logic [4:0] geo = SLOT;
    qeb_pkg::qeb_busreq_type req;
    logic [31:0] rdata;
    logic ack, gate, avail, busy;
    logic [NCH*12-1:0] val;
    logic [NCH-1:0] ovf, und;
    logic [31:0] seed = 32'hfaa1;
    logic [31:0] ra;
    logic [7:0] crate = 8'h00;
    logic [15:0] bs2 = 16'h0000;
    int fails = 0;
    int compares = 0;
    int evc = 0;
    qeb_note_type notes[$];

    qeb_formatter #(.NCH(NCH), .DEPTH(16)) DUT (
        .SYS_CLK_I(clk), .NRST_I(nrst), .BUS_REQ_I(req), .BUS_RDATA_O(rdata),
        .BUS_ACK_O(ack), .CONV_GATE_I(gate), .CONV_VALUE_I(val), .CONV_OVF_I(ovf),
        .CONV_UNDER_I(und), .AUX_PRESENT_I(aux), .GEO_SLOT_I(SLOT),
        .EVENT_AVAILABLE_O(avail), .BUSY_O(busy));
    qeb_bus_master bm (.clk_i(clk), .req_o(req));

    initial begin
        forever #50 clk = ~clk;
    end
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0);
    endfunction
    task automatic wrap_up();
        if (fails == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input logic r, input logic [15:0] a, input logic [15:0] d,
                       input logic [31:0] e);
        bm.q.push_back({r, ~r, 1'b0, a, d});
        notes.push_back({r, e});
    endtask
    task automatic drain();
        int t;
        for (t = 0; t < 3000 && (bm.q.size() > 0 || notes.size() > 0); t++) @(negedge clk);
        check("pending cycles", 32'h0, 32'(notes.size()));
    endtask
    // ****************************************
    // One gate and the readout of its event
    // ****************************************
    task automatic event_gate(input logic [NCH-1:0] ovm, input logic [NCH-1:0] unm);
        int i;
        int ch;
        logic [31:0] words[$];
        qeb_pkg::qeb_data_type dw;
        qeb_pkg::qeb_header_type hw;
        qeb_pkg::qeb_eoe_type ew;
        @(negedge clk);
        for (i = 0; i < NCH; i++) begin
            seed = lfsr(seed);
            val[12*i +: 12] = seed[11:0];
        end
        ovf = ovm;
        und = unm;
        gate = 1'b1;
        @(negedge clk);
        gate = 1'b0;
        for (i = 0; i < NCH; i++) begin
            ch = (i % 2 == 0) ? i / 2 : NCH / 2 + i / 2;
            if ((!ovf[ch] || bs2[3]) && (!und[ch] || (bs2[3] && bs2[4]))) begin
                dw = '{geo, qeb_pkg::TYPE_DATA, 3'h0, 5'(ch), 2'h0, und[ch], ovf[ch],
                       val[12*ch +: 12]};
                words.push_back(dw);
            end
        end
        check("busy", 32'(words.size() > 0), {31'h0, busy});
        if (words.size() > 0) begin
            hw = '{geo, qeb_pkg::TYPE_HEAD, crate, 2'h0, 6'(words.size()), 8'h00};
            ew = '{geo, qeb_pkg::TYPE_EOE, 24'(evc)};
            words.push_front(hw);
            words.push_back(ew);
            evc++;
        end else if (bs2[14]) begin
            evc++;
        end
        repeat (NCH + 5) @(negedge clk);
        if (words.size() <= 16) check("available", 32'(words.size() > 0), {31'h0, avail});
        if (words.size() == 0) words.push_back(qeb_pkg::NVD_WORD);
        foreach (words[j]) begin
            cyc(1'b1, 16'(4 * (j % 512)), 16'h0, words[j]);
            repeat (3) bm.q.push_back('0);
        end
        drain();
        check("available after read", 32'h0, {31'h0, avail});
    endtask
    // ****************************************
    // Result monitor
    // ****************************************
    always @(negedge clk) begin
        qeb_note_type n;
        if (nrst === 1'b1 && ack === 1'b1) begin
            if (notes.size() == 0) begin
                check("unexpected answer", 32'h0, 32'h1);
            end else begin
                n = notes.pop_front();
                if (n.chk) check("read data", n.val, rdata);
            end
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        wrap_up();
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        gate = 1'b0;
        val = '0;
        ovf = '0;
        und = '0;
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        cyc(1'b1, 16'h0000, 16'h0, qeb_pkg::NVD_WORD);
        cyc(1'b1, qeb_pkg::WIN_LAST, 16'h0, qeb_pkg::NVD_WORD);
        cyc(1'b1, 16'h2000, 16'h0, 32'h0);
        crate = 8'hc5;
        bm.q.push_back({3'b011, qeb_pkg::CRATE_OFS, 8'h00, crate});
        notes.push_back('0);
        bm.q.push_back({3'b101, qeb_pkg::STAT1_OFS, 16'h0});
        bm.q.push_back({3'b010, qeb_pkg::GEO_OFS, 16'h0005});
        cyc(1'b1, qeb_pkg::GEO_OFS, 16'h0, 32'(SLOT));
        drain();
        repeat (2) begin
            seed = lfsr(seed);
            ra = seed;
            seed = lfsr(seed);
            event_gate(ra, seed);
        end
        event_gate('1, '0);
        bs2 = 16'h4000;
        cyc(1'b0, qeb_pkg::BS2_OFS, bs2, 32'h0);
        drain();
        event_gate('0, '1);
        seed = lfsr(seed);
        event_gate(seed, ~seed);
        bs2 = 16'h4018;
        cyc(1'b0, qeb_pkg::BS2_OFS, 16'h0018, 32'h0);
        drain();
        seed = lfsr(seed);
        ra = seed;
        seed = lfsr(seed);
        event_gate(ra, seed);
        bs2 = 16'h0000;
        cyc(1'b0, qeb_pkg::BC2_OFS, 16'h4018, 32'h0);
        drain();
        event_gate(32'h7fff_fffe, 32'h0000_0000);
        // Without the connector the slot id is written, then applied by a single shot reset.
        aux = 1'b0;
        geo = 5'h05;
        cyc(1'b0, qeb_pkg::GEO_OFS, 16'(geo), 32'h0);
        cyc(1'b1, qeb_pkg::GEO_OFS, 16'h0, 32'(SLOT));
        cyc(1'b0, qeb_pkg::SSRST_OFS, 16'h0, 32'h0);
        bm.q.push_back('0);
        cyc(1'b1, qeb_pkg::GEO_OFS, 16'h0, 32'(geo));
        cyc(1'b1, qeb_pkg::STAT1_OFS, 16'h0, 32'h10);
        drain();
        evc = 0;
        event_gate(32'h00ff_ff00, 32'hff00_0000);
        wrap_up();
    end
endmodule
